//--- rtl/mcseq_coproc.sv
// Coprocessor end: handshake answers and data movement
module mcseq_coproc
   import mcseq_pkg::*;
#(
   parameter int MAX_WORDS = 16
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Core link
   mcseq_cp_if.coproc cp,
   // User side
   input wire logic accept,
   input wire logic commit,
   input wire logic [4:0] word_count,
   input wire logic [31:0] store_data,
   output logic [31:0] load_data,
   output logic load_strobe,
   output logic store_taken
);
   initial
   begin
      if (MAX_WORDS < 1 || MAX_WORDS > 31)
         $error("MAX_WORDS out of range");
   end

   typedef enum logic [2:0] {
      CP_IDLE = 3'b001,
      CP_WAIT = 3'b010,
      CP_XFER = 3'b100
   } mcseq_cp_st_t;

   typedef struct packed {
      mcseq_cp_st_t st;
      logic absent;
      logic busy;
      logic [4:0] left;
      logic [31:0] wdata;
      logic [31:0] ldata;
      logic lstb;
      logic stk;
      logic vn_q;
   } mcseq_cp_state_t;

   mcseq_cp_state_t s_reg, s_next;
   logic [4:0] cnt;

   // Handshake and transfer sequencing
   always_comb
   begin
      s_next = s_reg;
      s_next.lstb = 1'b0;
      s_next.stk = 1'b0;
      s_next.vn_q = cp.coproc_instr_valid_n;
      cnt = (word_count == 5'h00) ? 5'h01 : word_count;
      unique case (s_reg.st)
         CP_IDLE:
         begin
            s_next.absent = 1'b1;
            s_next.busy = 1'b1;
            // Only a fresh request is taken: the core drops its strobe a cycle late
            if (!cp.coproc_instr_valid_n && s_reg.vn_q && accept)
            begin
               s_next.absent = 1'b0;
               s_next.busy = !commit;
               s_next.st = commit ? CP_XFER : CP_WAIT;
               s_next.left = cnt;
               if (commit && cp.cp_op == MCSEQ_OP_CDP)
                  s_next.st = CP_IDLE;
            end
         end
         CP_WAIT:
         begin
            if (cp.coproc_instr_valid_n)
            begin
               s_next.st = CP_IDLE;
               s_next.absent = 1'b1;
               s_next.busy = 1'b1;
            end
            else if (commit)
            begin
               s_next.busy = 1'b0;
               s_next.st = (cp.cp_op == MCSEQ_OP_CDP) ? CP_IDLE : CP_XFER;
            end
         end
         CP_XFER:
         begin
            // Marks run one word ahead, as the core samples them a cycle late
            if (s_reg.absent && s_reg.busy)
               s_next.st = CP_IDLE;
            else if (s_reg.left <= 5'h01)
            begin
               s_next.absent = 1'b1;
               s_next.busy = 1'b1;
            end
            else
               s_next.left = s_reg.left - 5'h01;
            // A word stands on the bus only once the core has left the handshake
            if (cp.coproc_instr_valid_n && cp.bus_write)
            begin
               s_next.stk = 1'b1;
               s_next.wdata = store_data;
            end
            else if (cp.coproc_instr_valid_n)
            begin
               s_next.lstb = 1'b1;
               s_next.ldata = cp.cp_rdata;
            end
         end
         default:
         begin
            s_next.st = CP_IDLE;
         end
      endcase
      if (s_reg.st == CP_IDLE || s_reg.st == CP_WAIT)
         s_next.wdata = store_data;
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '{st: CP_IDLE, absent: 1'b1, busy: 1'b1, left: 5'h00,
                    wdata: MCSEQ_ZERO, ldata: MCSEQ_ZERO, lstb: 1'b0, stk: 1'b0,
                    vn_q: 1'b1};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign cp.coproc_absent = s_reg.absent;
   assign cp.coproc_busy = s_reg.busy;
   assign cp.cp_wdata = s_reg.wdata;
   assign load_data = s_reg.ldata;
   assign load_strobe = s_reg.lstb;
   assign store_taken = s_reg.stk;
endmodule

//--- rtl/mcseq_core.sv
// Core end: sequencer for store-multiple, swap, exception entry, coprocessor ops
// What this block does
// - Store-multiple first cycle computes first address
// - Store-multiple writes listed registers, updates base
// - Store-multiple ends with fetch, no internal cycle
// - Store-multiple never overwrites general registers
// - Swap reads cycle two, writes cycle three
// - Swap cycle four loads destination, no bus
// - Swap is byte or word both accesses
// - Aborted swap leaves destination unchanged
// - Atomic hold high across swap data cycles
// - Swap only in 32-bit instruction state
// - Entry cycle one: vector, link, saved status
// - Entry cycle two adjusts return, fetches vector
// - Entry cycle three only refills pipeline
// - Return base is the same for every exception cause
// - Coprocessor commits before dropping busy
// - Absent and busy signal refusal or waiting
// - Busy-wait on busy; interrupt may abandon
// - Coprocessor load reads sequentially, write low
// - Coprocessor store writes sequentially, write high
// - Coprocessor marks last transfer, absent busy high
// - First cycles form address, next writes base
// - Coprocessor ops only in 32-bit state
module mcseq_core
   import mcseq_pkg::*;
#(
   parameter int NREGS = MCSEQ_REG_COUNT
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Coprocessor link
   mcseq_cp_if.core cp,
   // Instruction request
   input wire logic start,
   input wire logic [2:0] op,
   input wire logic compressed_state,
   input wire logic byte_size,
   input wire logic [15:0] reg_list,
   input wire logic [31:0] base_addr,
   input wire logic [31:0] pc_in,
   input wire logic [31:0] src_data,
   input wire logic [1:0] exc_cause,
   input wire logic [31:0] vector_addr,
   input wire logic [31:0] status_in,
   input wire logic irq_pending,
   // Memory bus
   input wire logic [31:0] mem_rdata,
   input wire logic mem_abort,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic bus_write_out,
   output logic bus_byte,
   output logic [1:0] bus_cycle_type,
   output logic access_is_data,
   output logic atomic_hold,
   // Results
   output logic busy,
   output logic refused,
   output logic abandoned,
   output logic dest_we,
   output logic [31:0] dest_data,
   output logic base_we,
   output logic [31:0] base_wb,
   output logic [31:0] link_register,
   output logic [31:0] supervisor_saved_status,
   output logic [4:0] mode
);
   initial
   begin
      if (NREGS != 16)
         $error("NREGS must be 16");
   end

   typedef enum logic [8:0] {
      ST_IDLE = 9'b000000001,
      ST_STM = 9'b000000010,
      ST_SWR = 9'b000000100,
      ST_SWW = 9'b000001000,
      ST_SWD = 9'b000010000,
      ST_EX2 = 9'b000100000,
      ST_EX3 = 9'b001000000,
      ST_CPW = 9'b010000000,
      ST_CPX = 9'b100000000
   } mcseq_core_st_t;

   typedef struct packed {
      mcseq_core_st_t st;
      logic [2:0] op;
      logic [15:0] list;
      logic [31:0] addr;
      logic [31:0] pc;
      logic [31:0] hold;
      logic sz;
      logic aborted;
      logic [31:0] baddr;
      logic [31:0] wdata;
      logic wr;
      logic bsz;
      logic [1:0] cyc;
      logic dat;
      logic lock;
      logic bsy;
      logic ref_p;
      logic abn;
      logic dwe;
      logic [31:0] ddata;
      logic bwe;
      logic [31:0] bwb;
      logic [31:0] lr;
      logic [31:0] spsr;
      logic [4:0] md;
      logic coproc_instr_valid_n_n;
      logic [2:0] cpop;
   } mcseq_core_state_t;

   mcseq_core_state_t s_reg, s_next;
   logic [3:0] first_idx;

   // Lowest set register index
   function automatic logic [3:0] low_idx(input logic [15:0] l);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--)
         if (l[i])
            r = 4'(i);
      return r;
   endfunction

   // Sequencer next-state
   always_comb
   begin
      s_next = s_reg;
      s_next.dwe = 1'b0;
      s_next.bwe = 1'b0;
      s_next.ref_p = 1'b0;
      s_next.abn = 1'b0;
      s_next.wr = 1'b0;
      s_next.bsz = 1'b0;
      s_next.lock = 1'b0;
      s_next.dat = 1'b0;
      s_next.cyc = MCSEQ_CYC_S;
      first_idx = low_idx(s_reg.list);
      unique case (s_reg.st)
         ST_IDLE:
         begin
            s_next.bsy = 1'b0;
            s_next.coproc_instr_valid_n_n = 1'b1;
            if (start)
            begin
               s_next.op = op;
               s_next.pc = pc_in;
               s_next.aborted = 1'b0;
               s_next.sz = byte_size;
               s_next.list = reg_list;
               s_next.addr = base_addr;
               s_next.baddr = pc_in;
               s_next.cyc = MCSEQ_CYC_N;
               s_next.bsy = 1'b1;
               if (compressed_state && op != MCSEQ_OP_STM && op != MCSEQ_OP_EXC)
               begin
                  s_next.ref_p = 1'b1;
                  s_next.bsy = 1'b0;
               end
               else if (op == MCSEQ_OP_STM)
                  s_next.st = (reg_list == 16'h0000) ? ST_IDLE : ST_STM;
               else if (op == MCSEQ_OP_SWP)
                  s_next.st = ST_SWR;
               else if (op == MCSEQ_OP_EXC)
               begin
                  // Vector, link and saved status in cycle one
                  s_next.lr = pc_in;
                  s_next.spsr = status_in;
                  s_next.md = MCSEQ_SVC_MODE;
                  s_next.addr = vector_addr;
                  s_next.st = ST_EX2;
               end
               else
               begin
                  s_next.coproc_instr_valid_n_n = 1'b0;
                  s_next.cpop = op;
                  s_next.st = ST_CPW;
               end
            end
         end
         ST_STM:
         begin
            // One write per listed register, base written back on the last one
            s_next.baddr = s_reg.addr;
            s_next.wr = 1'b1;
            s_next.dat = 1'b1;
            s_next.wdata = {28'h000_0000, first_idx};
            s_next.addr = s_reg.addr + MCSEQ_WORD_STEP;
            s_next.list[first_idx] = 1'b0;
            if (s_reg.list == (16'h0001 << first_idx))
            begin
               s_next.st = ST_IDLE;
               s_next.bwe = 1'b1;
               s_next.bwb = s_reg.addr + MCSEQ_WORD_STEP;
               s_next.cyc = MCSEQ_CYC_N;
            end
         end
         ST_SWR:
         begin
            s_next.baddr = s_reg.addr;
            s_next.bsz = s_reg.sz;
            s_next.lock = 1'b1;
            s_next.dat = 1'b1;
            s_next.cyc = MCSEQ_CYC_N;
            s_next.st = ST_SWW;
         end
         ST_SWW:
         begin
            s_next.hold = s_reg.sz ? {24'h00_0000, mem_rdata[7:0]} : mem_rdata;
            s_next.aborted = mem_abort;
            s_next.wr = 1'b1;
            s_next.wdata = src_data;
            s_next.bsz = s_reg.sz;
            s_next.lock = 1'b1;
            s_next.dat = 1'b1;
            s_next.cyc = MCSEQ_CYC_I;
            s_next.st = ST_SWD;
         end
         ST_SWD:
         begin
            // Destination written without any bus access
            s_next.dwe = !(s_reg.aborted || mem_abort);
            s_next.ddata = s_reg.hold;
            s_next.baddr = s_reg.pc;
            s_next.st = ST_IDLE;
         end
         ST_EX2:
         begin
            s_next.baddr = s_reg.addr;
            s_next.lr = s_reg.lr + MCSEQ_WORD_STEP;
            s_next.st = ST_EX3;
         end
         ST_EX3:
         begin
            s_next.baddr = s_reg.addr + MCSEQ_WORD_STEP;
            s_next.st = ST_IDLE;
         end
         ST_CPW:
         begin
            s_next.cyc = MCSEQ_CYC_I;
            // The coprocessor answer is registered, so the first cycle only waits
            if (s_reg.cyc == MCSEQ_CYC_N)
               s_next.st = ST_CPW;
            else if (cp.coproc_absent && cp.coproc_busy)
            begin
               s_next.ref_p = 1'b1;
               s_next.coproc_instr_valid_n_n = 1'b1;
               s_next.st = ST_IDLE;
            end
            else if (cp.coproc_busy && irq_pending)
            begin
               s_next.abn = 1'b1;
               s_next.coproc_instr_valid_n_n = 1'b1;
               s_next.st = ST_IDLE;
            end
            else if (!cp.coproc_busy)
            begin
               s_next.coproc_instr_valid_n_n = 1'b1;
               if (s_reg.cpop == MCSEQ_OP_CDP)
                  s_next.st = ST_IDLE;
               else
               begin
                  s_next.st = ST_CPX;
                  s_next.baddr = s_reg.addr;
                  s_next.wr = (s_reg.cpop == MCSEQ_OP_STC);
                  s_next.wdata = cp.cp_wdata;
                  s_next.dat = 1'b1;
                  s_next.cyc = MCSEQ_CYC_S;
                  s_next.addr = s_reg.addr + MCSEQ_WORD_STEP;
               end
            end
         end
         ST_CPX:
         begin
            s_next.bwe = (s_reg.baddr == s_reg.addr - MCSEQ_WORD_STEP);
            s_next.bwb = s_reg.addr;
            s_next.wdata = cp.cp_wdata;
            if (cp.coproc_absent && cp.coproc_busy)
               s_next.st = ST_IDLE;
            else
            begin
               s_next.baddr = s_reg.addr;
               s_next.addr = s_reg.addr + MCSEQ_WORD_STEP;
               s_next.wr = (s_reg.cpop == MCSEQ_OP_STC);
               s_next.dat = 1'b1;
            end
         end
         default:
         begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.coproc_instr_valid_n_n <= 1'b1;
         s_reg.md <= 5'h10;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign cp.coproc_instr_valid_n = s_reg.coproc_instr_valid_n_n;
   assign cp.cp_op = s_reg.cpop;
   assign cp.bus_cycle_type = s_reg.cyc;
   assign cp.bus_write = s_reg.wr;
   assign cp.cp_rdata = mem_rdata;
   assign bus_addr = s_reg.baddr;
   assign bus_wdata = s_reg.wdata;
   assign bus_write_out = s_reg.wr;
   assign bus_byte = s_reg.bsz;
   assign bus_cycle_type = s_reg.cyc;
   assign access_is_data = s_reg.dat;
   assign atomic_hold = s_reg.lock;
   assign busy = s_reg.bsy;
   assign refused = s_reg.ref_p;
   assign abandoned = s_reg.abn;
   assign dest_we = s_reg.dwe;
   assign dest_data = s_reg.ddata;
   assign base_we = s_reg.bwe;
   assign base_wb = s_reg.bwb;
   assign link_register = s_reg.lr;
   assign supervisor_saved_status = s_reg.spsr;
   assign mode = s_reg.md;
endmodule

//--- rtl/mcseq_cp_if.sv
// Interface joining the core sequencer and the attached coprocessor
interface mcseq_cp_if
   import mcseq_pkg::*;
();
   logic coproc_instr_valid_n;
   logic coproc_absent;
   logic coproc_busy;
   logic [2:0] cp_op;
   logic [1:0] bus_cycle_type;
   logic bus_write;
   logic [31:0] cp_wdata;
   logic [31:0] cp_rdata;
   modport core
   (
      output coproc_instr_valid_n, cp_op, bus_cycle_type, bus_write, cp_rdata,
      input coproc_absent, coproc_busy, cp_wdata
   );
   modport coproc
   (
      input coproc_instr_valid_n, cp_op, bus_cycle_type, bus_write, cp_rdata,
      output coproc_absent, coproc_busy, cp_wdata
   );
endinterface

//--- rtl/mcseq_pkg.sv
// Shared constants for the multicycle bus and coprocessor sequencer
package mcseq_pkg;
   // ==========================================
   // Bus cycle type encodings
   localparam logic [1:0] MCSEQ_CYC_N = 2'h0;
   localparam logic [1:0] MCSEQ_CYC_S = 2'h1;
   localparam logic [1:0] MCSEQ_CYC_I = 2'h2;
   localparam logic [1:0] MCSEQ_CYC_C = 2'h3;
   // ==========================================
   // Operation codes
   localparam logic [2:0] MCSEQ_OP_STM = 3'h0;
   localparam logic [2:0] MCSEQ_OP_SWP = 3'h1;
   localparam logic [2:0] MCSEQ_OP_EXC = 3'h2;
   localparam logic [2:0] MCSEQ_OP_CDP = 3'h3;
   localparam logic [2:0] MCSEQ_OP_LDC = 3'h4;
   localparam logic [2:0] MCSEQ_OP_STC = 3'h5;
   // ==========================================
   // Exception causes
   localparam logic [1:0] MCSEQ_CAUSE_TRAP = 2'h0;
   localparam logic [1:0] MCSEQ_CAUSE_PABT = 2'h1;
   localparam logic [1:0] MCSEQ_CAUSE_DABT = 2'h2;
   localparam logic [1:0] MCSEQ_CAUSE_OTHER = 2'h3;
   // ==========================================
   // Address steps and reset values
   localparam logic [31:0] MCSEQ_WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] MCSEQ_ZERO = 32'h0000_0000;
   localparam logic [4:0] MCSEQ_SVC_MODE = 5'h13;
   localparam int MCSEQ_REG_COUNT = 16;
   localparam int MCSEQ_REG_IDX_W = 4;
endpackage

//--- tb/mcseq_properties.sv
// Concurrent checks on the link between the core and the coprocessor
module mcseq_properties
   import mcseq_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link signals
   input wire logic coproc_instr_valid_n,
   input wire logic coproc_absent,
   input wire logic coproc_busy,
   input wire logic [2:0] cp_op,
   input wire logic [1:0] bus_cycle_type,
   input wire logic bus_write,
   input wire logic [31:0] cp_wdata,
   input wire logic [31:0] cp_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Helper terms
   wire logic go = !coproc_instr_valid_n && !coproc_absent && !coproc_busy;
   wire logic ldst = (cp_op == MCSEQ_OP_LDC) || (cp_op == MCSEQ_OP_STC);
   wire logic xfer = coproc_instr_valid_n && !coproc_absent && !coproc_busy && ldst;
   wire logic waits = !coproc_instr_valid_n && !coproc_absent && coproc_busy;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Assertions
   AST_ABSENT_HAS_BUSY: assert property (coproc_absent |-> coproc_busy)
      else $error("absent high with busy low");
   AST_RESET_IDLE: assert property ($rose(rst_n) |->
      coproc_instr_valid_n && coproc_absent && coproc_busy)
      else $error("link not idle after reset");
   AST_HANDSHAKE_NO_WRITE: assert property (!coproc_instr_valid_n |-> !bus_write)
      else $error("write during handshake");
   AST_LOAD_WRITE_LOW: assert property (go && cp_op == MCSEQ_OP_LDC |=>
      coproc_instr_valid_n && !bus_write)
      else $error("load transfer not a read");
   AST_STORE_WRITE_HIGH: assert property (go && cp_op == MCSEQ_OP_STC |=>
      coproc_instr_valid_n && bus_write)
      else $error("store transfer not a write");
   AST_XFER_SEQUENTIAL: assert property (xfer |->
      bus_cycle_type == MCSEQ_CYC_S && bus_write == (cp_op == MCSEQ_OP_STC))
      else $error("transfer not sequential");
   AST_WAIT_SAME_OP: assert property (waits |=> $stable(cp_op))
      else $error("instruction changed while waiting");
   AST_CDP_DONE: assert property (go && cp_op == MCSEQ_OP_CDP |=> coproc_instr_valid_n)
      else $error("handshake kept after commit");
   AST_LAST_MARK: assert property (xfer ##1 (coproc_absent && coproc_busy) |->
      coproc_instr_valid_n && bus_write == (cp_op == MCSEQ_OP_STC))
      else $error("last transfer malformed");
   // Main scenarios reached
   cover property (xfer && cp_op == MCSEQ_OP_LDC);
   cover property (xfer && cp_op == MCSEQ_OP_STC);
   cover property (waits);
   cover property (go && cp_op == MCSEQ_OP_CDP);
endmodule

//--- tb/tb.sv
// Self-checking bench joining both sequencer ends
module tb
   import mcseq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 1;
   // ==========================================
   // Stimulus and observed signals
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic start, compressed_state, byte_size, irq_pending, mem_abort, accept, commit;
   logic [2:0] op;
   logic [1:0] exc_cause;
   logic [4:0] word_count;
   logic [15:0] reg_list;
   logic [31:0] base_addr, pc_in, src_data, vector_addr, status_in, mem_rdata, store_data;
   logic [31:0] bus_addr, bus_wdata, dest_data, base_wb, link_register;
   logic [31:0] supervisor_saved_status, load_data;
   logic [1:0] bus_cycle_type;
   logic [4:0] mode;
   logic bus_write_out, bus_byte, access_is_data, atomic_hold, busy, refused, abandoned;
   logic dest_we, base_we, load_strobe, store_taken;
   logic [31:0] wa[$], wd[$], ra[$], q[$];
   logic [31:0] last_dest, last_base;
   logic [1:0] aw;
   int cnt[11];
   int fails = 0;
   int samples_checked = 0;
   logic [2:0] ro[4] = '{MCSEQ_OP_SWP, MCSEQ_OP_CDP, MCSEQ_OP_LDC, MCSEQ_OP_STC};
   logic [2:0] xo[2] = '{MCSEQ_OP_LDC, MCSEQ_OP_STC};
   logic [31:0] ix[3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_000F};
   // ==========================================
   // Both ends and the checker
   mcseq_cp_if cpi();
   mcseq_core i_mcseq_core (.mclk, .rst_n, .cp(cpi.core), .start, .op, .compressed_state,
      .byte_size, .reg_list, .base_addr, .pc_in, .src_data, .exc_cause, .vector_addr,
      .status_in, .irq_pending, .mem_rdata, .mem_abort, .bus_addr, .bus_wdata,
      .bus_write_out, .bus_byte, .bus_cycle_type, .access_is_data, .atomic_hold, .busy,
      .refused, .abandoned, .dest_we, .dest_data, .base_we, .base_wb, .link_register,
      .supervisor_saved_status, .mode);
   mcseq_coproc i_mcseq_coproc (.mclk, .rst_n, .cp(cpi.coproc), .accept, .commit,
      .word_count, .store_data, .load_data, .load_strobe, .store_taken);
   mcseq_properties i_mcseq_properties (.mclk, .rst_n,
      .coproc_instr_valid_n(cpi.coproc_instr_valid_n), .coproc_absent(cpi.coproc_absent),
      .coproc_busy(cpi.coproc_busy), .cp_op(cpi.cp_op), .bus_cycle_type(cpi.bus_cycle_type),
      .bus_write(cpi.bus_write), .cp_wdata(cpi.cp_wdata), .cp_rdata(cpi.cp_rdata));
   // Clock at 25 MHz
   always #20 mclk = ~mclk;
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Starts one operation and logs the bus until the core is idle again
   task automatic run(input logic [2:0] o, input int hold, input bit by_irq);
      int k;
      logic pw;
      logic [31:0] pa;
      wa = {};
      wd = {};
      ra = {};
      cnt = '{default: 0};
      last_dest = 'x;
      last_base = 'x;
      aw = 'x;
      pw = 1'b0;
      pa = '0;
      k = 0;
      @(posedge mclk);
      #DLY;
      op = o;
      start = 1'b1;
      while (k < 60 && (k < 3 || busy === 1'b1))
      begin
         @(posedge mclk);
         #DLY;
         start = 1'b0;
         if (k == hold && by_irq) irq_pending = 1'b1;
         if (k == hold && !by_irq) commit = 1'b1;
         if (bus_write_out === 1'b1)
         begin
            wa.push_back(bus_addr);
            wd.push_back(bus_wdata);
         end
         if (bus_write_out === 1'b0 && access_is_data === 1'b1 &&
             bus_cycle_type !== MCSEQ_CYC_I && cpi.coproc_instr_valid_n === 1'b1)
            ra.push_back(bus_addr);
         if (pw === 1'b1 && bus_write_out !== 1'b1)
            aw = {access_is_data, bus_cycle_type === MCSEQ_CYC_I};
         if (dest_we === 1'b1) last_dest = dest_data;
         if (base_we === 1'b1) last_base = base_wb;
         cnt[0] += (dest_we === 1'b1);
         cnt[1] += (base_we === 1'b1);
         cnt[2] += (refused === 1'b1);
         cnt[3] += (abandoned === 1'b1);
         cnt[4] += (atomic_hold === 1'b1);
         cnt[5] += (load_strobe === 1'b1);
         cnt[6] += (store_taken === 1'b1);
         cnt[7] += (atomic_hold === 1'b1 && bus_byte === 1'b1);
         cnt[9] += (access_is_data === 1'b0 && pa === vector_addr &&
                    bus_addr === vector_addr + MCSEQ_WORD_STEP);
         cnt[10] += (cpi.coproc_instr_valid_n === 1'b0);
         pw = bus_write_out;
         pa = bus_addr;
         k++;
      end
      irq_pending = 1'b0;
   endtask
   // ==========================================
   // Test sequence
   initial
   begin
      {start, compressed_state, byte_size, irq_pending, mem_abort, accept, commit} = '0;
      op = MCSEQ_OP_STM;
      {reg_list, base_addr, pc_in, src_data, vector_addr, status_in, mem_rdata} = '0;
      store_data = '0;
      exc_cause = MCSEQ_CAUSE_TRAP;
      word_count = 5'h01;
      repeat (12) @(posedge mclk);
      #DLY;
      rst_n = 1'b1;
      chk(mode, 32'h0000_0010);
      chk({cpi.coproc_instr_valid_n, cpi.coproc_absent, cpi.coproc_busy}, 3'h7);
      $display("test reset done");
      // Word and byte swaps, an aborted one
      base_addr = 32'h0000_0100;
      src_data = 32'hA5A5_0001;
      mem_rdata = 32'h1234_5678;
      for (int b = 0; b < 2; b++)
      begin
         byte_size = b[0];
         run(MCSEQ_OP_SWP, 99, 1'b0);
         chk(ra[0], base_addr);
         chk(wa[0], base_addr);
         chk(wd[0] & (b ? 32'h0000_00FF : '1), src_data & (b ? 32'h0000_00FF : '1));
         chk(cnt[4], 2);
         chk(cnt[7], 2 * b);
         chk(cnt[0], 1);
         chk(last_dest, mem_rdata & (b ? 32'h0000_00FF : '1));
      end
      mem_abort = 1'b1;
      run(MCSEQ_OP_SWP, 99, 1'b0);
      chk(cnt[0], 0);
      mem_abort = 1'b0;
      $display("test swap done");
      // Compressed state refuses swap and coprocessor work
      compressed_state = 1'b1;
      accept = 1'b1;
      commit = 1'b1;
      foreach (ro[i])
      begin
         run(ro[i], 99, 1'b0);
         chk(cnt[2], 1);
         chk(cnt[4] + cnt[10], 0);
      end
      compressed_state = 1'b0;
      $display("test state done");
      // Store-multiple of three registers, then of none
      reg_list = 16'h8005;
      base_addr = 32'h0000_0200;
      run(MCSEQ_OP_STM, 99, 1'b0);
      chk(wa.size(), 3);
      foreach (ix[i])
      begin
         chk(wa[i], base_addr + 4 * i);
         chk(wd[i], ix[i]);
      end
      chk(cnt[0], 0);
      chk(last_base, base_addr + 32'h0000_000C);
      chk(aw, 2'h0);
      reg_list = 16'h0000;
      run(MCSEQ_OP_STM, 99, 1'b0);
      chk(wa.size(), 0);
      $display("test store multiple done");
      // Exception entry for every cause
      for (int c = 0; c < 4; c++)
      begin
         exc_cause = c[1:0];
         pc_in = 32'h0000_1000 + 16 * c;
         vector_addr = 32'h0000_0008 + 4 * c;
         status_in = 32'h0000_00D0 + c;
         run(MCSEQ_OP_EXC, 99, 1'b0);
         chk(link_register, pc_in + MCSEQ_WORD_STEP);
         chk(supervisor_saved_status, status_in);
         chk(mode, MCSEQ_SVC_MODE);
         chk(cnt[9], 1);
      end
      $display("test entry done");
      // Data processing: late commit, abandon, no coprocessor
      commit = 1'b0;
      run(MCSEQ_OP_CDP, 3, 1'b0);
      chk(cnt[2] + cnt[3], 0);
      chk(cnt[10] > 2, 1);
      commit = 1'b0;
      run(MCSEQ_OP_CDP, 3, 1'b1);
      chk(cnt[3], 1);
      accept = 1'b0;
      run(MCSEQ_OP_CDP, 99, 1'b0);
      chk(cnt[2], 1);
      $display("test data processing done");
      // Coprocessor loads and stores of one and three words after a wait
      accept = 1'b1;
      mem_rdata = 32'h1357_9BDF;
      store_data = 32'hCAFE_0042;
      base_addr = 32'h0000_0300;
      for (int n = 1; n < 4; n += 2)
      begin
         foreach (xo[j])
         begin
            word_count = n[4:0];
            commit = 1'b0;
            run(xo[j], 2, 1'b0);
            q = j ? wa : ra;
            chk(q.size(), n);
            foreach (q[i]) chk(q[i], base_addr + 4 * i);
            chk(cnt[5 + j], n);
            chk(last_base, base_addr + 4 * n);
         end
      end
      chk(load_data, mem_rdata);
      chk(wd[0], store_data);
      chk(cpi.cp_rdata, mem_rdata);
      $display("test transfer done");
      results();
   end
   // Watchdog cuts a hung run short
   initial
   begin
      #200000;
      fails++;
      results();
   end
endmodule
